// ---- hw/clk_ctrl_pkg.sv ----
// constants and types shared by the peripheral clock gate and rate control block
package clk_ctrl_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] OFF_RATE = 8'h06;
    localparam logic [ADDR_W-1:0] OFF_GATE = 8'h07;
    localparam logic [ADDR_W-1:0] OFF_KEEP = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_SHORT = 8'h09;
    localparam logic [ADDR_W-1:0] OFF_PROT = 8'h0A;

    // reset values
    localparam logic [DATA_W-1:0] RST_RATE = 16'h0000;
    localparam logic [DATA_W-1:0] RST_GATE = 16'h0000;
    localparam logic [DATA_W-1:0] RST_KEEP = 16'h0000;
    localparam logic [DATA_W-1:0] RST_SHORT = 16'hF000;
    localparam logic [1:0] RST_PROT = 2'h0;

    // rate register fields
    localparam int RATE_TIMER_BIT = 15;
    localparam int RATE_PWM_BIT = 13;
    localparam int RATE_SERIAL_BIT = 12;
    localparam logic [DATA_W-1:0] RATE_MASK = 16'hB000;

    // peripheral bit positions, shared by gate and stop keep registers
    localparam int P_TIMER_CHANNEL_ZERO = 0;
    localparam int P_TIMER_CHANNEL_ONE = 1;
    localparam int P_INTERVAL_TIMER = 2;
    localparam int P_DELAY_BLOCK = 3;
    localparam int P_WATCHDOG_TIMER = 4;
    localparam int P_PWM = 5;
    localparam int P_SPI = 6;
    localparam int P_SERIAL_PORT = 7;
    localparam int P_I2C = 8;
    localparam int P_AMPLIFIER_ZERO = 9;
    localparam int P_AMPLIFIER_ONE = 10;
    localparam int P_CONVERTER_ZERO = 11;
    localparam int P_CONVERTER_ONE = 12;
    localparam int P_COMPARATOR_ZERO = 13;
    localparam int P_COMPARATOR_ONE = 14;
    localparam int P_COMPARATOR_TWO = 15;
    localparam int NUM_PERIPH = 16;

    // peripherals that may run at 3x, and those with a single clock input
    localparam logic [NUM_PERIPH-1:0] FAST_CAPABLE = 16'h00A3;
    localparam logic [NUM_PERIPH-1:0] SINGLE_CLOCK = 16'h0080;

    // short address layout
    localparam int SHORT_HI = 15;
    localparam int SHORT_LO = 6;
    localparam int SHORT_W = SHORT_HI - SHORT_LO + 1;
    localparam int LOW_W = 6;
    localparam int FULL_ADDR_W = 24;
    localparam logic [7:0] SHORT_TOP = 8'h00;
    localparam logic [SHORT_W-1:0] RST_SHORT_FIELD = RST_SHORT[SHORT_HI:SHORT_LO];
    localparam int SHORT_DELAY = 5;
    localparam int SHORT_PIPE = SHORT_DELAY - 1;

    // protection field: bit 1 locks, bit 0 turns protection on
    localparam int PROT_ON_BIT = 0;
    localparam int PROT_LOCK_BIT = 1;
    localparam int PROT_LO = 2;
    localparam int PROT_HI = 3;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

endpackage

// ---- hw/clk_gate_cell.sv ----
// latch based glitch free clock gate
`timescale 1ns/1ps
module clk_gate_cell (
    input wire logic clk_in, // clock to be gated
    input wire logic en,     // gate enable, sampled while clk_in is low
    output logic gclk        // gated clock
);
    logic en_l;

    // transparent while low so the enable cannot change inside a high phase
    always_latch begin
        if (!clk_in) begin
            en_l = en;
        end
    end

    assign gclk = clk_in & en_l;
endmodule

// ---- hw/short_base_pipe.sv ----
// delay line that holds a new short address base back for the core pipeline
`timescale 1ns/1ps
module short_base_pipe
    import clk_ctrl_pkg::*;
(
    input wire logic clk,                  // system clock
    input wire logic sys_rst,              // synchronous reset
    input wire logic ce,                   // clock enable
    input wire logic [SHORT_W-1:0] din,    // stored base field
    output logic [SHORT_W-1:0] dout        // base field after the delay
);
    logic [SHORT_W-1:0] stage_q [SHORT_PIPE];
    logic [SHORT_W-1:0] stage_d [SHORT_PIPE];

    always_comb begin
        stage_d[0] = din;
        for (int i = 1; i < SHORT_PIPE; i++) begin
            stage_d[i] = stage_q[i-1];
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < SHORT_PIPE; i++) begin
            if (sys_rst) begin
                stage_q[i] <= RST_SHORT_FIELD;
            end else if (ce) begin
                stage_q[i] <= stage_d[i];
            end
        end
    end

    assign dout = stage_q[SHORT_PIPE-1];
endmodule

// ---- hw/periph_clock_gate_rate_ctrl.sv ----
// peripheral clock gating, stop mode keep, 3x rate select and short address base
//
// Contract
// - rate bit 15 runs the timer at core rate when 0, at 3x when 1.
// - rate bit 13 runs the PWM at core rate when 0, at 3x when 1.
// - rate bit 12 runs the serial port at core rate when 0, at 3x when 1.
// - fast clock comes from the PLL 3x output, held low unless PLL selected.
// - single clock peripheral runs wholly on 3x; its bus side moves to 3x too.
// - separate clock peripheral moves only its run clock to 3x.
// - gate register holds one enable bit per peripheral in the fixed order.
// - gate bit 0 stops the peripheral clock, 1 supplies it.
// - a gated off peripheral has no function, its I/O included.
// - in stop mode an enabled clock stops unless its keep bit is 1.
// - keep register shares the gate bit map, 1 keeps clock in stop, resets 0.
// - gate bit 0 overrides the keep bit in every mode.
// - bus accesses cannot reach a peripheral whose clock is off.
// - short address is zeros, stored bits 15 to 6, then six instruction bits.
// - short address base resets to the peripheral region start.
// - a new short address base takes effect five cycles after the write.
// - protection on blocks rate, gate and keep writes; it can lock till reset.
`timescale 1ns/1ps
module periph_clock_gate_rate_ctrl
    import clk_ctrl_pkg::*;
(
    input wire logic clk,                         // system clock, 50 MHz
    input wire logic sys_rst,                     // synchronous reset, active high
    input wire logic ce,                          // clock enable, freezes state when low
    input wire reg_req_t req,                     // register access from the core
    output logic [DATA_W-1:0] reg_rdata,          // read data, one cycle after rd
    input wire logic stop_mode,                   // core is in stop mode
    input wire logic pll_sel,                     // PLL selected in the clock gen module
    input wire logic pll_clk3x,                   // PLL 3x master clock
    input wire logic [LOW_W-1:0] io_low,          // low address bits from the instruction
    output logic [FULL_ADDR_W-1:0] short_addr,    // full short I/O address
    output logic [NUM_PERIPH-1:0] periph_clk,     // per peripheral bus clock
    output logic [NUM_PERIPH-1:0] run_clk,        // per peripheral run clock
    output logic [NUM_PERIPH-1:0] periph_active,  // peripheral function and I/O allowed
    output logic [NUM_PERIPH-1:0] bus_access_ok   // bus access may reach the peripheral
);
    ////////////////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0] rate_q, rate_d;
    logic [NUM_PERIPH-1:0] gate_q, gate_d;
    logic [NUM_PERIPH-1:0] keep_q, keep_d;
    logic [SHORT_W-1:0] short_q, short_d;
    logic [1:0] prot_q, prot_d;
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic [FULL_ADDR_W-1:0] saddr_q, saddr_d;
    logic [SHORT_W-1:0] short_eff;
    logic clk_wr_ok;
    logic [NUM_PERIPH-1:0] run_en;
    logic [NUM_PERIPH-1:0] fast_on;
    logic [NUM_PERIPH-1:0] core_en, fast_en;
    logic [NUM_PERIPH-1:0] core_g, fast_g;

    assign clk_wr_ok = !prot_q[PROT_ON_BIT];

    always_comb begin
        rate_d = rate_q;
        gate_d = gate_q;
        keep_d = keep_q;
        short_d = short_q;
        prot_d = prot_q;
        rdata_d = rdata_q;
        if (req.wr) begin
            unique case (req.addr)
                OFF_RATE: begin
                    if (clk_wr_ok) begin
                        rate_d = req.wdata & RATE_MASK;
                    end
                end
                OFF_GATE: begin
                    if (clk_wr_ok) begin
                        gate_d = req.wdata;
                    end
                end
                OFF_KEEP: begin
                    if (clk_wr_ok) begin
                        keep_d = req.wdata;
                    end
                end
                OFF_SHORT: begin
                    short_d = req.wdata[SHORT_HI:SHORT_LO];
                end
                OFF_PROT: begin
                    if (!prot_q[PROT_LOCK_BIT]) begin
                        prot_d = req.wdata[PROT_HI:PROT_LO];
                    end
                end
                default: begin
                end
            endcase
        end
        if (req.rd) begin
            unique case (req.addr)
                OFF_RATE: rdata_d = rate_q;
                OFF_GATE: rdata_d = gate_q;
                OFF_KEEP: rdata_d = keep_q;
                OFF_SHORT: rdata_d = {short_q, {LOW_W{1'b0}}};
                OFF_PROT: rdata_d = {{(DATA_W-PROT_HI-1){1'b0}}, prot_q, {PROT_LO{1'b0}}};
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rate_q <= RST_RATE;
            gate_q <= RST_GATE;
            keep_q <= RST_KEEP;
            short_q <= RST_SHORT_FIELD;
            prot_q <= RST_PROT;
            rdata_q <= '0;
        end else if (ce) begin
            rate_q <= rate_d;
            gate_q <= gate_d;
            keep_q <= keep_d;
            short_q <= short_d;
            prot_q <= prot_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // short address: the delay line plus the output register make up the delay
    short_base_pipe u_short_pipe (
        .clk(clk),
        .sys_rst(sys_rst),
        .ce(ce),
        .din(short_q),
        .dout(short_eff)
    );

    always_comb begin
        saddr_d = {SHORT_TOP, short_eff, io_low};
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            saddr_q <= {SHORT_TOP, RST_SHORT_FIELD, {LOW_W{1'b0}}};
        end else if (ce) begin
            saddr_q <= saddr_d;
        end
    end

    assign short_addr = saddr_q;

    ////////////////////////////////////////////////////////////////////////////
    // gate bit dominates the keep bit, keep only matters in stop
    assign run_en = gate_q & (~{NUM_PERIPH{stop_mode}} | keep_q);
    assign periph_active = run_en;
    assign bus_access_ok = run_en;

    // without the PLL the 3x source is dead, so never steer onto it
    always_comb begin
        fast_on = '0;
        fast_on[P_TIMER_CHANNEL_ZERO] = rate_q[RATE_TIMER_BIT] & pll_sel;
        fast_on[P_TIMER_CHANNEL_ONE] = rate_q[RATE_TIMER_BIT] & pll_sel;
        fast_on[P_PWM] = rate_q[RATE_PWM_BIT] & pll_sel;
        fast_on[P_SERIAL_PORT] = rate_q[RATE_SERIAL_BIT] & pll_sel;
    end

    assign fast_en = run_en & fast_on & FAST_CAPABLE;
    assign core_en = run_en & ~(fast_on & SINGLE_CLOCK);

    for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_periph
        clk_gate_cell u_core_gate (
            .clk_in(clk),
            .en(core_en[i]),
            .gclk(core_g[i])
        );
        if (FAST_CAPABLE[i]) begin : g_fast
            clk_gate_cell u_fast_gate (
                .clk_in(pll_clk3x),
                .en(fast_en[i]),
                .gclk(fast_g[i])
            );
        end else begin : g_slow
            assign fast_g[i] = 1'b0;
        end
        // single clock peripherals move whole; the others keep a core bus clock
        if (SINGLE_CLOCK[i]) begin : g_single
            assign periph_clk[i] = core_g[i] | fast_g[i];
        end else begin : g_split
            assign periph_clk[i] = core_g[i];
        end
        assign run_clk[i] = fast_on[i] ? fast_g[i] : core_g[i];
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_timer_rate;
        fast_en[P_TIMER_CHANNEL_ZERO] |-> rate_q[RATE_TIMER_BIT] && pll_sel;
    endproperty
    a_timer_rate: assert property (p_timer_rate) else $error("timer fast without rate bit");

    property p_pwm_rate;
        (ce && req.wr && req.addr == OFF_RATE && clk_wr_ok && req.wdata[RATE_PWM_BIT])
            ##1 (pll_sel && gate_q[P_PWM] && !stop_mode) |-> fast_on[P_PWM];
    endproperty
    a_pwm_rate: assert property (p_pwm_rate) else $error("pwm rate bit ignored");

    property p_serial_single;
        fast_on[P_SERIAL_PORT] |-> !core_en[P_SERIAL_PORT];
    endproperty
    a_serial_single: assert property (p_serial_single) else $error("serial on two clocks");

    property p_no_pll;
        !pll_sel |-> fast_en == '0;
    endproperty
    a_no_pll: assert property (p_no_pll) else $error("fast clock without pll");

    property p_gate_write;
        (ce && req.wr && req.addr == OFF_GATE && clk_wr_ok) |=> gate_q == $past(req.wdata);
    endproperty
    a_gate_write: assert property (p_gate_write) else $error("gate write lost");

    property p_stop_keep;
        stop_mode |-> run_en == (gate_q & keep_q);
    endproperty
    a_stop_keep: assert property (p_stop_keep) else $error("stop keep mismatch");

    property p_gate_wins;
        !stop_mode |-> run_en == gate_q && (bus_access_ok & ~gate_q) == '0;
    endproperty
    a_gate_wins: assert property (p_gate_wins) else $error("gate override broken");

    // the new base is loaded by the edge five cycles on, so it is sampled one edge later
    property p_short_delay;
        (ce && req.wr && req.addr == OFF_SHORT) ##1 (ce && !req.wr)[*5]
            |=> short_addr[SHORT_HI:SHORT_LO] == $past(req.wdata[SHORT_HI:SHORT_LO], 6);
    endproperty
    a_short_delay: assert property (p_short_delay) else $error("short base delay wrong");

    property p_short_top;
        short_addr[FULL_ADDR_W-1:SHORT_HI+1] == SHORT_TOP;
    endproperty
    a_short_top: assert property (p_short_top) else $error("short address top not zero");

    property p_lock;
        prot_q[PROT_LOCK_BIT] |=> $stable(prot_q);
    endproperty
    a_lock: assert property (p_lock) else $error("locked protection changed");

    property p_protect;
        (ce && req.wr && req.addr == OFF_RATE && !clk_wr_ok) |=> $stable(rate_q);
    endproperty
    a_protect: assert property (p_protect) else $error("protected rate write took");

    property p_rsvd;
        (rate_q & ~RATE_MASK) == '0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved rate bit set");

    property p_keep_write;
        (ce && req.wr && req.addr == OFF_KEEP && clk_wr_ok) |=> keep_q == $past(req.wdata);
    endproperty
    a_keep_write: assert property (p_keep_write) else $error("keep write lost");

    property p_rate_read;
        (ce && req.rd && req.addr == OFF_RATE) |=> (reg_rdata & ~RATE_MASK) == '0;
    endproperty
    a_rate_read: assert property (p_rate_read) else $error("reserved rate bit read");

    property p_short_read;
        (ce && req.rd && req.addr == OFF_SHORT) |=> reg_rdata[LOW_W-1:0] == '0;
    endproperty
    a_short_read: assert property (p_short_read) else $error("short low bits read");

    property p_gate_off;
        ((core_en | fast_en) & ~gate_q) == '0;
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("clock without gate bit");

    property p_split_bus;
        fast_on[P_PWM] |-> core_en[P_PWM] == run_en[P_PWM];
    endproperty
    a_split_bus: assert property (p_split_bus) else $error("pwm bus clock moved");

    property p_stop_off;
        (stop_mode && !keep_q[P_WATCHDOG_TIMER]) |-> !bus_access_ok[P_WATCHDOG_TIMER];
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("bus open to stopped clock");

    // reset loads zero low bits, so the first edge after it is left out
    property p_short_low;
        ($past(ce) && !$past(sys_rst)) |-> short_addr[LOW_W-1:0] == $past(io_low);
    endproperty
    a_short_low: assert property (p_short_low) else $error("short low bits wrong");

    property p_freeze;
        !ce |=> $stable(rate_q) && $stable(gate_q) && $stable(keep_q) && $stable(short_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with ce low");

    c_fast_timer: cover property (fast_en[P_TIMER_CHANNEL_ZERO]);
    c_stop_kept: cover property (stop_mode && run_en != '0);
    c_locked_on: cover property (prot_q[PROT_LOCK_BIT] && prot_q[PROT_ON_BIT]);
    c_serial_fast: cover property (fast_en[P_SERIAL_PORT]);
    c_short_moved: cover property (ce && req.wr && req.addr == OFF_SHORT);
endmodule

// ---- sim/clk_far_side_model.sv ----
// far side model: PLL 3x source plus peripherals that count their clock edges
`timescale 1ns/1ps
module clk_far_side_model
    import clk_ctrl_pkg::*;
(
    input wire logic pll_sel,                    // PLL selected in the clock gen module
    output logic pll_clk3x,                      // 3x master clock
    input wire logic [NUM_PERIPH-1:0] run_clk,   // run clocks seen by peripherals
    input wire logic [NUM_PERIPH-1:0] periph_clk, // bus clocks seen by peripherals
    output int run_cnt [NUM_PERIPH],             // rising edges of each run clock
    output int bus_cnt [NUM_PERIPH]              // rising edges of each bus clock
);
    logic osc = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // free oscillator, phase unrelated to clk; output low when PLL not selected
    initial begin
        #1.1;
        forever begin
            #3.333;
            osc = ~osc;
        end
    end
    assign pll_clk3x = osc & pll_sel;

    ////////////////////////////////////////////////////////////////////////////////
    // each peripheral only notices edges that actually reach it
    for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_cnt
        // two-state counters start at zero, so one process drives each
        always @(posedge run_clk[i]) run_cnt[i] <= run_cnt[i] + 1;
        always @(posedge periph_clk[i]) bus_cnt[i] <= bus_cnt[i] + 1;
    end
endmodule

// ---- sim/periph_clock_gate_rate_ctrl_tb_top.sv ----
// self-checking bench for the peripheral clock gate and rate control block
`timescale 1ns/1ps
module periph_clock_gate_rate_ctrl_tb_top;
    import clk_ctrl_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ce = 1'b1;
    reg_req_t req = '0;
    logic stop_mode = 1'b0;
    logic pll_sel = 1'b0;
    logic pll_clk3x;
    logic [LOW_W-1:0] io_low = 6'h00;
    logic [DATA_W-1:0] reg_rdata;
    logic [FULL_ADDR_W-1:0] short_addr;
    logic [NUM_PERIPH-1:0] periph_clk, run_clk, periph_active, bus_access_ok;
    int run_cnt [NUM_PERIPH];
    int bus_cnt [NUM_PERIPH];
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;

    periph_clock_gate_rate_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .req(req),
        .reg_rdata(reg_rdata), .stop_mode(stop_mode), .pll_sel(pll_sel),
        .pll_clk3x(pll_clk3x), .io_low(io_low), .short_addr(short_addr),
        .periph_clk(periph_clk), .run_clk(run_clk), .periph_active(periph_active),
        .bus_access_ok(bus_access_ok));
    clk_far_side_model u_far (.pll_sel(pll_sel), .pll_clk3x(pll_clk3x), .run_clk(run_clk),
        .periph_clk(periph_clk), .run_cnt(run_cnt), .bus_cnt(bus_cnt));

    initial begin
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // generous ceiling, the sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // all bus tasks enter and leave at a falling edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk);
        req.wr = 1'b0;
        // idle edge so the next strobe never rises in the same step
        @(negedge clk);
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk);
        req.rd = 1'b0;
        chk(24'(reg_rdata), 24'(exp));
        @(negedge clk);
    endtask

    task automatic do_reset();
        sys_rst = 1'b1;
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        // first request only after an edge has seen reset low
        @(negedge clk);
    endtask

    // ten core cycles: core rate gives about 10 edges, 3x about 30
    task automatic edges(input int idx, input int want_run, input int want_bus);
        int r0;
        int b0;
        @(negedge clk);
        r0 = run_cnt[idx];
        b0 = bus_cnt[idx];
        repeat (10) @(negedge clk);
        chk(24'(run_cnt[idx] - r0 >= want_run - 2 && run_cnt[idx] - r0 <= want_run + 2), 24'h1);
        chk(24'(bus_cnt[idx] - b0 >= want_bus - 2 && bus_cnt[idx] - b0 <= want_bus + 2), 24'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        rd_chk(OFF_RATE, 16'h0000);
        rd_chk(OFF_KEEP, 16'h0000);
        rd_chk(OFF_SHORT, 16'hF000);
        chk(short_addr, 24'h00F000);
        chk(24'(periph_active), 24'h0);
        wr(OFF_RATE, 16'hFFFF);
        rd_chk(OFF_RATE, 16'hB000);
        wr(OFF_RATE, 16'h0000);
        rd_chk(8'h20, 16'h0000);
        // walk one enable bit through every peripheral position
        for (int i = 0; i < NUM_PERIPH; i++) begin
            wr(OFF_GATE, 16'(1 << i));
            chk(24'(periph_active), 24'(1 << i));
            chk(24'(bus_access_ok), 24'(1 << i));
        end
        edges(P_TIMER_CHANNEL_ZERO, 0, 0);
        edges(P_COMPARATOR_TWO, 10, 10);
        // stop mode: only kept clocks survive, and gate still wins
        wr(OFF_GATE, 16'hFFFF);
        wr(OFF_KEEP, 16'h00A0);
        stop_mode = 1'b1;
        @(negedge clk);
        chk(24'(periph_active), 24'h0000A0);
        edges(P_WATCHDOG_TIMER, 0, 0);
        edges(P_PWM, 10, 10);
        wr(OFF_KEEP, 16'hFFFF);
        wr(OFF_GATE, 16'h0080);
        chk(24'(periph_active), 24'h000080);
        stop_mode = 1'b0;
        wr(OFF_GATE, 16'hFFFF);
        // rates; the core selects the PLL before any rate bit is set
        pll_sel = 1'b1;
        wr(OFF_RATE, 16'h8000);
        edges(P_TIMER_CHANNEL_ONE, 30, 10);
        edges(P_TIMER_CHANNEL_ZERO, 30, 10);
        edges(P_PWM, 10, 10);
        wr(OFF_RATE, 16'h2000);
        edges(P_PWM, 30, 10);
        wr(OFF_RATE, 16'h1000);
        edges(P_SERIAL_PORT, 30, 30);
        edges(P_TIMER_CHANNEL_ZERO, 10, 10);
        wr(OFF_RATE, 16'h0000);
        pll_sel = 1'b0;
        edges(P_SERIAL_PORT, 10, 10);
        // short base takes effect exactly five cycles after the write edge
        io_low = 6'h15;
        wr(OFF_SHORT, 16'hF7FF);
        rd_chk(OFF_SHORT, 16'hF7C0);
        repeat (1) @(negedge clk);
        chk(short_addr, 24'h00F015);
        @(negedge clk);
        chk(short_addr, 24'h00F7D5);
        wr(OFF_SHORT, 16'hF000);
        // clock enable low freezes every register, so this write is lost
        ce = 1'b0;
        wr(OFF_GATE, 16'h0000);
        ce = 1'b1;
        rd_chk(OFF_GATE, 16'hFFFF);
        // protection on, then locked on; a later clear must not take
        wr(OFF_PROT, 16'h0004);
        wr(OFF_GATE, 16'h0001);
        rd_chk(OFF_GATE, 16'hFFFF);
        wr(OFF_PROT, 16'h000C);
        wr(OFF_PROT, 16'h0000);
        wr(OFF_KEEP, 16'h0000);
        rd_chk(OFF_KEEP, 16'hFFFF);
        wr(OFF_RATE, 16'h8000);
        rd_chk(OFF_RATE, 16'h0000);
        do_reset();
        wr(OFF_GATE, 16'h0021);
        rd_chk(OFF_GATE, 16'h0021);
        rd_chk(OFF_SHORT, 16'hF000);
        print_verdict();
    end
endmodule
